// *** hdl/dac_pkg.sv ***
/*
  Constants for the drive address echo and command acceptance block:
  task file offsets, field positions, command classes and timing.
  Assumes a 20 MHz core clock.
*/
package dac_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // Offsets on the 4-bit register address
  localparam logic [3:0] OFS_DRIVE_HEAD  = 4'h6;
  localparam logic [3:0] OFS_STATUS_CMD  = 4'h7;
  localparam logic [3:0] OFS_ALT_STATUS  = 4'he;
  localparam logic [3:0] OFS_DRIVE_ADDR  = 4'hf;

  // Drive/head register fields
  localparam int DH_DRV_BIT   = 4;
  localparam int DH_HEAD_LSB  = 0;
  localparam int DH_HEAD_MSB  = 3;
  localparam logic [7:0] DH_RESET = 8'ha0;

  // Drive address register fields
  localparam int DA_WIP_BIT   = 6;
  localparam int DA_HEAD_LSB  = 2;
  localparam int DA_HEAD_MSB  = 5;
  localparam int DA_DS1_BIT   = 1;
  localparam int DA_DS0_BIT   = 0;

  // Status register fields
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_RDY_BIT   = 6;
  localparam int ST_DSC_BIT   = 4;
  localparam int ST_DRQ_BIT   = 3;
  localparam int ST_ERR_BIT   = 0;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    DAC_CLASS_1 = 2'b01,
    DAC_CLASS_2 = 2'b10,
    DAC_CLASS_3 = 2'b11
  } dac_class_e;

  // Opcodes that accept with a write buffer set up
  localparam logic [7:0] OP_FORMAT_TRACK   = 8'h50;
  localparam logic [7:0] OP_WRITE_BUFFER   = 8'he8;
  localparam logic [7:0] OP_WRITE_LONG_A   = 8'h32;
  localparam logic [7:0] OP_WRITE_LONG_B   = 8'h33;
  localparam logic [7:0] OP_WRITE_SEC_A    = 8'h30;
  localparam logic [7:0] OP_WRITE_SEC_B    = 8'h31;
  localparam logic [7:0] OP_WRITE_NOERASE  = 8'h38;
  localparam logic [7:0] OP_WRITE_VERIFY   = 8'h3c;
  localparam logic [7:0] OP_WRITE_MULT     = 8'hc5;
  localparam logic [7:0] OP_WRITE_MULT_NE  = 8'hcd;

  // Timing limits as printed and derived cycle counts (longest: round down)
  localparam int BUSY_MAX_NS   = 400;
  localparam int BUSY_MAX_CYC  = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int DRQ2_MAX_US   = 700;
  localparam int DRQ2_MAX_CYC  = (DRQ2_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int DRQ3_MAX_MS   = 20;
  localparam int DRQ3_MAX_CYC  = (DRQ3_MAX_MS * 1000000) / CLK_PERIOD_NS;

  localparam int TIMER_W = 20;

endpackage : dac_pkg

// *** hdl/dac_class_decode.sv ***
/*
  Registered lookup from command opcode to acceptance class.
  Assumes opcode is stable in the cycle it is sampled with en_i.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_class_decode
  import dac_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       en_i,
  input  wire logic [7:0] opcode_i,
  output var dac_class_e  class_o
);

  dac_class_e class_reg;
  dac_class_e class_next;

  always_comb begin
    case (opcode_i)
      OP_FORMAT_TRACK, OP_WRITE_BUFFER, OP_WRITE_LONG_A, OP_WRITE_LONG_B,
      OP_WRITE_SEC_A, OP_WRITE_SEC_B, OP_WRITE_NOERASE,
      OP_WRITE_VERIFY: class_next = DAC_CLASS_2;
      OP_WRITE_MULT, OP_WRITE_MULT_NE: class_next = DAC_CLASS_3;
      default: class_next = DAC_CLASS_1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      class_reg <= DAC_CLASS_1;
    end else if (ce_i && en_i) begin
      class_reg <= class_next;
    end
  end

  assign class_o = class_reg;

endmodule : dac_class_decode
`default_nettype wire

// *** hdl/dac_top.sv ***
/*
  Drive address echo register and ATA command acceptance sequencer.
  Host I/O strobes, address and data arrive as asynchronous pins and are
  synchronised; back-end handshakes are on clk_i.
*/
// Function
// - Write-in-progress bit reads 0 during a write, else 1.
// - Bits 5..2 return inverted head-select bits 3..0 of drive/head.
// - Drive-one select bit reads 0 only when drive 1 active and selected.
// - Drive-zero select bit reads 0 only when drive 0 active and selected.
// - Class 1 command: busy asserted within 400 ns of the write.
// - Class 2: busy 400 ns, data request within 700 us, busy drops.
// - Class 3: busy 400 ns, data request within 20 ms, busy drops.
// - Drive/head low nibble holds head number or block address 27..24.
// - Busy is status bit 7; command register locked out while set.
// - Data request, status bit 3, set when data must move.
`timescale 1ns/1ps
`default_nettype none
module dac_top
  import dac_pkg::*;
#(
  parameter int DRQ2_LIMIT = DRQ2_MAX_CYC,
  parameter int DRQ3_LIMIT = DRQ3_MAX_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       host_iowr_n_i,
  input  wire logic       host_iord_n_i,
  input  wire logic [3:0] host_addr_i,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe_n_o,
  input  wire logic       card_is_drive1_i,
  input  wire logic       write_active_i,
  input  wire logic       ready_i,
  input  wire logic       buffer_ready_i,
  input  wire logic       cmd_done_i,
  input  wire logic       xfer_done_i,
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_opcode_o,
  output logic      [1:0] cmd_class_o,
  output logic      [7:0] drive_head_o,
  output logic            busy_o,
  output logic            drq_o,
  output logic            err_o
);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DECODE = 3'b001,
    ST_EXEC   = 3'b010,
    ST_WAIT   = 3'b011,
    ST_XFER   = 3'b100
  } dac_state_e;

  typedef struct packed {
    logic               wr_s1;
    logic               wr_s2;
    logic               wr_last;
    logic               rd_s1;
    logic               rd_s2;
    logic         [3:0] addr_s1;
    logic         [3:0] addr_s2;
    logic         [7:0] data_s1;
    logic         [7:0] data_s2;
    logic         [7:0] dh;
    logic         [7:0] opcode;
    dac_state_e         state;
    logic               busy;
    logic               drq;
    logic               err;
    logic               cmd_valid;
    logic [TIMER_W-1:0] timer;
    logic         [7:0] rdata;
  } dac_state_s;

  localparam logic [TIMER_W-1:0] LIMIT2 = TIMER_W'(DRQ2_LIMIT);
  localparam logic [TIMER_W-1:0] LIMIT3 = TIMER_W'(DRQ3_LIMIT);
  localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);

  dac_state_s st_reg;
  dac_state_s st_next;
  dac_class_e cls;

  logic       wr_event;
  logic       cmd_take;
  logic       drv_sel1;
  logic [7:0] drive_addr;
  logic [7:0] status;

  dac_class_decode u_class (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .en_i     (cmd_take),
    .opcode_i (st_reg.data_s2),
    .class_o  (cls)
  );

  // Write taken once the synchronised strobe shows low; data set up before
  assign wr_event = st_reg.wr_s2 && !st_reg.wr_last;
  // Class latched only on an accepted command, so later writes keep it
  assign cmd_take = wr_event && !st_reg.busy && st_reg.state == ST_IDLE &&
                    st_reg.addr_s2 == OFS_STATUS_CMD;
  assign drv_sel1 = st_reg.dh[DH_DRV_BIT];

  always_comb begin
    drive_addr = BYTE_ZERO;
    drive_addr[DA_WIP_BIT] = !write_active_i;
    drive_addr[DA_HEAD_MSB:DA_HEAD_LSB] =
      ~st_reg.dh[DH_HEAD_MSB:DH_HEAD_LSB];
    drive_addr[DA_DS1_BIT] = !(drv_sel1 && card_is_drive1_i);
    drive_addr[DA_DS0_BIT] = !(!drv_sel1 && !card_is_drive1_i);
  end

  always_comb begin
    status = BYTE_ZERO;
    status[ST_BUSY_BIT] = st_reg.busy;
    status[ST_RDY_BIT]  = ready_i;
    status[ST_DSC_BIT]  = ready_i;
    status[ST_DRQ_BIT]  = st_reg.drq;
    status[ST_ERR_BIT]  = st_reg.err;
  end

  always_comb begin
    st_next = st_reg;
    st_next.wr_s1   = !host_iowr_n_i;
    st_next.wr_s2   = st_reg.wr_s1;
    st_next.wr_last = st_reg.wr_s2;
    st_next.rd_s1   = !host_iord_n_i;
    st_next.rd_s2   = st_reg.rd_s1;
    st_next.addr_s1 = host_addr_i;
    st_next.addr_s2 = st_reg.addr_s1;
    st_next.data_s1 = host_data_i;
    st_next.data_s2 = st_reg.data_s1;
    st_next.cmd_valid = 1'b0;

    case (st_reg.addr_s2)
      OFS_DRIVE_HEAD: st_next.rdata = st_reg.dh;
      OFS_STATUS_CMD,
      OFS_ALT_STATUS: st_next.rdata = status;
      OFS_DRIVE_ADDR: st_next.rdata = drive_addr;
      default:        st_next.rdata = BYTE_ZERO;
    endcase

    // Writes to the drive address offset fall through untouched
    if (wr_event && !st_reg.busy) begin
      if (st_reg.addr_s2 == OFS_DRIVE_HEAD) begin
        st_next.dh = st_reg.data_s2;
      end
    end

    case (st_reg.state)
      ST_IDLE: begin
        // Command taken only while not busy; a write under busy is dropped
        if (wr_event && !st_reg.busy &&
            st_reg.addr_s2 == OFS_STATUS_CMD) begin
          st_next.opcode = st_reg.data_s2;
          st_next.busy   = 1'b1;
          st_next.drq    = 1'b0;
          st_next.err    = 1'b0;
          st_next.state  = ST_DECODE;
        end
      end
      ST_DECODE: begin
        st_next.cmd_valid = 1'b1;
        st_next.timer = (cls == DAC_CLASS_3) ? LIMIT3 : LIMIT2;
        if (cls == DAC_CLASS_1) begin
          st_next.state = ST_EXEC;
        end else begin
          st_next.state = ST_WAIT;
        end
      end
      ST_EXEC: begin
        if (cmd_done_i) begin
          st_next.busy  = 1'b0;
          st_next.state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // Busy drops in the same cycle the data request rises
        if (buffer_ready_i) begin
          st_next.drq   = 1'b1;
          st_next.busy  = 1'b0;
          st_next.state = ST_XFER;
        end else if (st_reg.timer == TIMER_ONE) begin
          // Buffer never came: report error instead of hanging busy
          st_next.err   = 1'b1;
          st_next.busy  = 1'b0;
          st_next.state = ST_IDLE;
        end else begin
          st_next.timer = st_reg.timer - TIMER_ONE;
        end
      end
      ST_XFER: begin
        if (xfer_done_i) begin
          st_next.drq   = 1'b0;
          st_next.state = ST_IDLE;
        end
      end
      default: begin
        st_next.state = ST_IDLE;
        st_next.busy  = 1'b0;
        st_next.drq   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.dh <= DH_RESET;
      st_reg.state <= ST_IDLE;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Bit 7 is driven as zero at the drive address offset and at unused offsets; a socket adapter may cut it off
  assign host_data_o      = st_reg.rdata;
  assign host_data_oe_n_o = !st_reg.rd_s2;
  assign cmd_valid_o      = st_reg.cmd_valid;
  assign cmd_opcode_o     = st_reg.opcode;
  assign cmd_class_o      = cls;
  assign drive_head_o     = st_reg.dh;
  assign busy_o           = st_reg.busy;
  assign drq_o            = st_reg.drq;
  assign err_o            = st_reg.err;

endmodule : dac_top
`default_nettype wire

// *** tb/dac_top_properties.sv ***
/* Concurrent checks on the dac_top ports.
   Assumes ce_i is held high by the bench. */
`timescale 1ns/1ps
`default_nettype none
module dac_top_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [3:0] host_addr_i,
  input wire logic [7:0] host_data_o,
  input wire logic       card_is_drive1_i,
  input wire logic       write_active_i,
  input wire logic       buffer_ready_i,
  input wire logic       cmd_done_i,
  input wire logic       xfer_done_i,
  input wire logic       cmd_valid_o,
  input wire logic [1:0] cmd_class_o,
  input wire logic [7:0] drive_head_o,
  input wire logic       busy_o,
  input wire logic       drq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wait;
    cmd_valid_o && cmd_class_o != 2'b01 ##[1:60] busy_o && buffer_ready_i;
  endsequence
  // Six quiet cycles cover the pin synchroniser and the read register
  sequence s_quiet;
    (host_addr_i == 4'hf && $stable(drive_head_o) &&
     $stable(card_is_drive1_i) && $stable(write_active_i))[*6];
  endsequence
  property p_vbusy; cmd_valid_o |-> busy_o; endproperty
  property p_vone; cmd_valid_o |=> !cmd_valid_o; endproperty
  property p_done;
    busy_o && cmd_class_o == 2'b01 && cmd_done_i |=> !busy_o;
  endproperty
  property p_drq; s_wait |=> drq_o && !busy_o; endproperty
  property p_xfer; drq_o && xfer_done_i |=> !drq_o; endproperty
  property p_wip;
    s_quiet |-> host_data_o[7:6] == {1'b0, !write_active_i};
  endproperty
  property p_head; s_quiet |-> host_data_o[5:2] == ~drive_head_o[3:0];
  endproperty
  property p_sel;
    s_quiet |-> host_data_o[1:0] == {!(drive_head_o[4] && card_is_drive1_i),
                                     drive_head_o[4] || card_is_drive1_i};
  endproperty
  a_vbusy: assert property (p_vbusy) else $error("no busy");
  a_vone: assert property (p_vone) else $error("long pulse");
  a_done: assert property (p_done) else $error("busy stuck");
  a_drq: assert property (p_drq) else $error("no drq");
  a_xfer: assert property (p_xfer) else $error("drq stuck");
  a_wip: assert property (p_wip) else $error("wip bit");
  a_head: assert property (p_head) else $error("head bits");
  a_sel: assert property (p_sel) else $error("select bits");
endmodule : dac_top_properties
bind dac_top dac_top_properties chk_u (.clk_i, .rst_i, .host_addr_i,
  .host_data_o, .card_is_drive1_i, .write_active_i, .buffer_ready_i,
  .cmd_done_i, .xfer_done_i, .cmd_valid_o, .cmd_class_o, .drive_head_o,
  .busy_o, .drq_o);
`default_nettype wire

// *** tb/dac_host_model.sv ***
/* Host processor model on the task file pins.
   Assumes a free running clk_i; drives after falling edges. */
`timescale 1ns/1ps
`default_nettype none
module dac_host_model
  import dac_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_i,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic      [3:0] addr_o,
  output logic      [7:0] data_o,
  output logic            stb_o,
  output logic      [7:0] val_o
);
  initial begin
    {wr_n_o, rd_n_o, stb_o, addr_o, data_o, val_o} = {3'b110, 20'h00000};
  end
  // Setup and strobe widths exceed the two clocks the synchroniser needs
  task automatic io(input logic wr, input logic [3:0] a,
                    input logic [7:0] d, input logic chk);
    addr_o = a;
    data_o = d;
    repeat (3) @(negedge clk_i);
    if (wr) wr_n_o = 1'b0;
    else rd_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    val_o = dev_i;
    stb_o = chk & !wr;
    {wr_n_o, rd_n_o} = 2'b11;
    repeat (4) @(negedge clk_i);
    stb_o = 1'b0;
    // Released lines show the inverse, never a stale copy
    addr_o = ~a;
    data_o = ~d;
    // One more edge so a following call never reassigns in this time step
    @(negedge clk_i);
  endtask : io
  // Offset f is read only to test it, never relied on
  task automatic cmd(input logic [7:0] dh, input logic [7:0] op);
    for (int n = 0; n < 40; n++) begin
      io(1'b0, OFS_ALT_STATUS, 8'h00, 1'b0);
      if (val_o[ST_BUSY_BIT] === 1'b0) break;
    end
    io(1'b1, OFS_DRIVE_HEAD, dh, 1'b0);
    io(1'b1, OFS_STATUS_CMD, op, 1'b0);
  endtask : cmd
endmodule : dac_host_model
`default_nettype wire

// *** tb/drive_address_and_command_accept_tb.sv ***
/* Self-checking bench for dac_top driven by the host model.
   Assumes a 20 MHz clock and shortened buffer wait limits. */
`timescale 1ns/1ps
`default_nettype none
module drive_address_and_command_accept_tb
  import dac_pkg::*;
;
  logic       clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, ready_i = 1'b0;
  logic       card_is_drive1_i = 1'b0, write_active_i = 1'b0;
  logic       buffer_ready_i = 1'b0, cmd_done_i = 1'b0, xfer_done_i = 1'b0;
  logic       host_iowr_n_i, host_iord_n_i, host_data_oe_n_o, stb;
  logic       cmd_valid_o, busy_o, drq_o, err_o;
  logic [1:0] cmd_class_o;
  logic [3:0] host_addr_i;
  logic [7:0] host_data_i, host_data_o, cmd_opcode_o, drive_head_o, val, dh;
  logic [7:0] rq[$];
  logic [9:0] cq[$];
  logic [7:0] ops[7] = '{8'hec, 8'h90, 8'h30, 8'h50, 8'he8, 8'hc5, 8'hcd};
  logic [1:0] cls[7] = '{2'b01, 2'b01, 2'b10, 2'b10, 2'b10, 2'b11, 2'b11};
  int         mismatches = 0, samples_checked = 0, cycles = 0;
  dac_top #(.DRQ2_LIMIT(60), .DRQ3_LIMIT(80)) dut_u (
    .clk_i, .rst_i, .ce_i, .host_iowr_n_i, .host_iord_n_i, .host_addr_i,
    .host_data_i, .host_data_o, .host_data_oe_n_o, .card_is_drive1_i,
    .write_active_i, .ready_i, .buffer_ready_i, .cmd_done_i, .xfer_done_i,
    .cmd_valid_o, .cmd_opcode_o, .cmd_class_o, .drive_head_o, .busy_o,
    .drq_o, .err_o);
  dac_host_model host_u (.clk_i, .dev_i(host_data_o), .wr_n_o(host_iowr_n_i),
    .rd_n_o(host_iord_n_i), .addr_o(host_addr_i), .data_o(host_data_i),
    .stb_o(stb), .val_o(val));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rq.push_back(exp);
    host_u.io(1'b0, a, 8'h00, 1'b1);
  endtask : rd
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask : pulse
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  always @(negedge stb) check(val, rq.pop_front());
  always @(posedge stb) check({7'h00, host_data_oe_n_o}, 8'h00);
  always @(negedge clk_i) begin
    if (cmd_valid_o === 1'b1) begin
      check(cmd_opcode_o, cq[0][7:0]);
      check({6'h00, cmd_class_o}, {6'h00, cq[0][9:8]});
      void'(cq.pop_front());
    end
  end
  initial begin
    void'($urandom(32'hd3b540f9));
    ready_i = 1'($urandom);
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    rd(4'h3, 8'h00);
    for (int i = 0; i < 4; i++) begin
      dh = 8'($urandom);
      {card_is_drive1_i, write_active_i} = 2'($urandom);
      host_u.io(1'b1, OFS_DRIVE_HEAD, dh, 1'b0);
      for (int k = 0; k < 2; k++) begin
        rd(OFS_DRIVE_ADDR, {1'b0, ~write_active_i, ~dh[3:0],
           ~(dh[4] & card_is_drive1_i), dh[4] | card_is_drive1_i});
        host_u.io(1'b1, OFS_DRIVE_ADDR, ~dh, 1'b0);
      end
      rd(OFS_DRIVE_HEAD, dh);
    end
    // Last opcode gets no buffer, so its wait must run out
    for (int i = 0; i < 7; i++) begin
      dh = 8'($urandom);
      cq.push_back({cls[i], ops[i]});
      host_u.cmd(dh, ops[i]);
      check({7'h00, busy_o}, 8'h01);
      host_u.io(1'b1, OFS_DRIVE_HEAD, ~dh, 1'b0);
      if (cls[i] == 2'b01) pulse(cmd_done_i);
      else if (i < 6) pulse(buffer_ready_i);
      for (int n = 0; n < 99 && busy_o !== 1'b0; n++) @(negedge clk_i);
      rd(OFS_DRIVE_HEAD, dh);
      rd(OFS_STATUS_CMD, {1'b0, ready_i, 1'b0, ready_i,
         cls[i] != 2'b01 && i < 6, 2'b00, i == 6});
      check({7'h00, drq_o}, {7'h00, cls[i] != 2'b01 && i < 6});
      check({7'h00, err_o}, {7'h00, i == 6});
      pulse(xfer_done_i);
      rd(OFS_ALT_STATUS, {1'b0, ready_i, 1'b0, ready_i, 3'b000, i == 6});
    end
    end_of_test();
  end
endmodule : drive_address_and_command_accept_tb
`default_nettype wire
